// *** logic/vpiu_arbiter.sv ***
// combinational priority tree: highest level wins, ties to smallest vector
module vpiu_arbiter #(
   parameter int N = 23
) (
   input wire logic [N-1:0] pend,
   input wire logic [2*N-1:0] levels,
   output logic found,
   output logic [4:0] win_vec,
   output logic [1:0] win_lvl
);
   always_comb begin
      found = 1'b0;
      win_vec = 5'h00;
      win_lvl = 2'h0;
      // ascending scan, strict compare keeps the lower vector on a tie
      for (int i = 0; i < N; i++) begin
         if (pend[i] && (!found || levels[2*i +: 2] > win_lvl)) begin
            found = 1'b1;
            win_vec = 5'(i);
            win_lvl = levels[2*i +: 2];
         end
      end
   end
endmodule // vpiu_arbiter

// *** logic/vpiu_pkg.sv ***
// package: vector numbers, levels, offsets and boot locations for the interrupt unit
package vpiu_pkg;
   localparam int NUM_VEC = 23;
   localparam int VEC_W = 5;
   localparam int ADDR_W = 21;
   localparam logic [1:0] LVL_MAX = 2'h3;
   // fixed levels
   localparam logic [1:0] CORE_EXC_LVL = 2'h3;
   localparam logic [1:0] SWI2_LVL = 2'h2;
   localparam logic [1:0] SWI1_LVL = 2'h1;
   localparam logic [1:0] SWI0_LVL = 2'h0;
   // programmable ranges
   localparam logic [1:0] DBG_LVL_MIN = 2'h1;
   localparam logic [1:0] DBG_LVL_MAX = 2'h3;
   localparam logic [1:0] PER_LVL_MIN = 2'h0;
   localparam logic [1:0] PER_LVL_MAX = 2'h2;
   // vector numbers
   localparam logic [4:0] VEC_FIRST = 5'h02;
   localparam logic [4:0] VEC_ILLEGAL = 5'h02;
   localparam logic [4:0] VEC_SWI3 = 5'h03;
   localparam logic [4:0] VEC_STACK_OVF = 5'h04;
   localparam logic [4:0] VEC_MISALIGN = 5'h05;
   localparam logic [4:0] VEC_DBG_STEP = 5'h06;
   localparam logic [4:0] VEC_DBG_BKPT0 = 5'h07;
   localparam logic [4:0] VEC_DBG_TRACE = 5'h09;
   localparam logic [4:0] VEC_DBG_TX_EMPTY = 5'h0A;
   localparam logic [4:0] VEC_DBG_RX_FULL = 5'h0B;
   localparam logic [4:0] VEC_SWI2 = 5'h0E;
   localparam logic [4:0] VEC_SWI1 = 5'h0F;
   localparam logic [4:0] VEC_SWI0 = 5'h10;
   localparam logic [4:0] VEC_EXT_A = 5'h11;
   localparam logic [4:0] VEC_EXT_B = 5'h12;
   localparam logic [4:0] VEC_LOW_VOLT = 5'h14;
   localparam logic [4:0] VEC_CLK_SYNTH = 5'h15;
   localparam logic [4:0] VEC_FLASH_ERR = 5'h16;
   // table entry size in program words
   localparam int VEC_STRIDE = 2;
   // boot locations, internal-boot mode
   localparam logic [20:0] BOOT_RESET_ADDR = 21'h04_0000;
   localparam logic [20:0] BOOT_WATCHDOG_ADDR = 21'h04_0002;
   localparam logic [20:0] TABLE_BASE_RESET = 21'h00_0000;

   typedef struct packed {
      logic valid;
      logic [4:0] vector;
      logic [1:0] level;
      logic [20:0] fetch_addr;
   } vpiu_grant_t;
endpackage

// *** logic/vpiu_top.sv ***
// vectored priority interrupt unit: level arbitration, vector fetch address, boot location
// Operation
// - higher levels always served before lower levels
// - equal level: smallest vector number wins
// - fetch address is table base plus offset
// - core exceptions vectors 2-5 fixed level 3
// - debug sources programmable levels one to three
// - external, voltage, clock, flash levels zero to two
// - software sets levels; soft interrupts fixed
// - entries 0 and 1 are reset overlays
// - boot at 04 0000, watchdog 04 0002
module vpiu_top (
   input wire logic clock,
   input wire logic reset_n,
   // core exceptions, vectors two to five
   input wire logic exc_illegal,
   input wire logic exc_swi3,
   input wire logic exc_stack_ovf,
   input wire logic exc_misalign,
   // debug unit sources, one bit each
   input wire logic [4:0] debug_unit_req,
   // software interrupts
   input wire logic swi2_req,
   input wire logic swi1_req,
   input wire logic swi0_req,
   // peripheral sources
   input wire logic external_request_a,
   input wire logic external_request_b,
   input wire logic low_voltage_req,
   input wire logic clk_synth_req,
   input wire logic flash_module_err_req,
   // level settings, two bits per source
   input wire logic [9:0] debug_unit_level,
   input wire logic [9:0] periph_level,
   // core side
   input wire logic [20:0] vector_table_base,
   input wire logic [1:0] core_mask_level,
   input wire logic watchdog_reset,
   output vpiu_pkg::vpiu_grant_t grant,
   output logic [20:0] boot_addr
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // a setting outside its window is pulled to the nearest edge, never refused
   function automatic logic [1:0] clamp_lvl(input logic [1:0] v, input logic [1:0] lo,
                                            input logic [1:0] hi);
      if (v < lo)
         return lo;
      else if (v > hi)
         return hi;
      else
         return v;
   endfunction

   // debug window is one to three
   function automatic logic [1:0] dbg_clamp(input logic [1:0] v);
      return clamp_lvl(v, vpiu_pkg::DBG_LVL_MIN, vpiu_pkg::DBG_LVL_MAX);
   endfunction

   // peripheral window is zero to two
   function automatic logic [1:0] per_clamp(input logic [1:0] v);
      return clamp_lvl(v, vpiu_pkg::PER_LVL_MIN, vpiu_pkg::PER_LVL_MAX);
   endfunction

   // each entry holds one two-word call, so offsets step by the stride
   function automatic logic [20:0] vec_offset(input logic [4:0] v);
      return 21'(v) * 21'(vpiu_pkg::VEC_STRIDE);
   endfunction

   // ---------------------------------------------------------------
   // debug unit levels
   // ---------------------------------------------------------------
   logic [1:0] step_lvl;
   logic [1:0] bkpt0_lvl;
   logic [1:0] trace_lvl;
   logic [1:0] tx_empty_lvl;
   logic [1:0] rx_full_lvl;

   always_comb begin
      // debug sources never fall below level one
      step_lvl = dbg_clamp(debug_unit_level[1:0]);
      bkpt0_lvl = dbg_clamp(debug_unit_level[3:2]);
      trace_lvl = dbg_clamp(debug_unit_level[5:4]);
      tx_empty_lvl = dbg_clamp(debug_unit_level[7:6]);
      rx_full_lvl = dbg_clamp(debug_unit_level[9:8]);
   end

   // ---------------------------------------------------------------
   // peripheral levels
   // ---------------------------------------------------------------
   logic [1:0] ext_a_lvl;
   logic [1:0] ext_b_lvl;
   logic [1:0] low_volt_lvl;
   logic [1:0] clk_synth_lvl;
   logic [1:0] flash_err_lvl;

   always_comb begin
      // peripherals never reach the core exception level
      ext_a_lvl = per_clamp(periph_level[1:0]);
      ext_b_lvl = per_clamp(periph_level[3:2]);
      low_volt_lvl = per_clamp(periph_level[5:4]);
      clk_synth_lvl = per_clamp(periph_level[7:6]);
      flash_err_lvl = per_clamp(periph_level[9:8]);
   end

   // ---------------------------------------------------------------
   // pending vector and level tables
   // ---------------------------------------------------------------
   logic [vpiu_pkg::NUM_VEC-1:0] pend;
   logic [2*vpiu_pkg::NUM_VEC-1:0] levels;

   always_comb begin
      // reserved entries and the reset overlays stay idle at level zero
      pend = '0;
      levels = '0;

      // core exceptions, fixed at the top level
      pend[vpiu_pkg::VEC_ILLEGAL] = exc_illegal;
      levels[2*int'(vpiu_pkg::VEC_ILLEGAL) +: 2] = vpiu_pkg::CORE_EXC_LVL;
      pend[vpiu_pkg::VEC_SWI3] = exc_swi3;
      levels[2*int'(vpiu_pkg::VEC_SWI3) +: 2] = vpiu_pkg::CORE_EXC_LVL;
      pend[vpiu_pkg::VEC_STACK_OVF] = exc_stack_ovf;
      levels[2*int'(vpiu_pkg::VEC_STACK_OVF) +: 2] = vpiu_pkg::CORE_EXC_LVL;
      pend[vpiu_pkg::VEC_MISALIGN] = exc_misalign;
      levels[2*int'(vpiu_pkg::VEC_MISALIGN) +: 2] = vpiu_pkg::CORE_EXC_LVL;

      // debug unit sources
      pend[vpiu_pkg::VEC_DBG_STEP] = debug_unit_req[0];
      levels[2*int'(vpiu_pkg::VEC_DBG_STEP) +: 2] = step_lvl;
      pend[vpiu_pkg::VEC_DBG_BKPT0] = debug_unit_req[1];
      levels[2*int'(vpiu_pkg::VEC_DBG_BKPT0) +: 2] = bkpt0_lvl;
      pend[vpiu_pkg::VEC_DBG_TRACE] = debug_unit_req[2];
      levels[2*int'(vpiu_pkg::VEC_DBG_TRACE) +: 2] = trace_lvl;
      pend[vpiu_pkg::VEC_DBG_TX_EMPTY] = debug_unit_req[3];
      levels[2*int'(vpiu_pkg::VEC_DBG_TX_EMPTY) +: 2] = tx_empty_lvl;
      pend[vpiu_pkg::VEC_DBG_RX_FULL] = debug_unit_req[4];
      levels[2*int'(vpiu_pkg::VEC_DBG_RX_FULL) +: 2] = rx_full_lvl;

      // software interrupts at fixed levels
      pend[vpiu_pkg::VEC_SWI2] = swi2_req;
      levels[2*int'(vpiu_pkg::VEC_SWI2) +: 2] = vpiu_pkg::SWI2_LVL;
      pend[vpiu_pkg::VEC_SWI1] = swi1_req;
      levels[2*int'(vpiu_pkg::VEC_SWI1) +: 2] = vpiu_pkg::SWI1_LVL;
      pend[vpiu_pkg::VEC_SWI0] = swi0_req;
      levels[2*int'(vpiu_pkg::VEC_SWI0) +: 2] = vpiu_pkg::SWI0_LVL;

      // peripheral sources
      pend[vpiu_pkg::VEC_EXT_A] = external_request_a;
      levels[2*int'(vpiu_pkg::VEC_EXT_A) +: 2] = ext_a_lvl;
      pend[vpiu_pkg::VEC_EXT_B] = external_request_b;
      levels[2*int'(vpiu_pkg::VEC_EXT_B) +: 2] = ext_b_lvl;
      pend[vpiu_pkg::VEC_LOW_VOLT] = low_voltage_req;
      levels[2*int'(vpiu_pkg::VEC_LOW_VOLT) +: 2] = low_volt_lvl;
      pend[vpiu_pkg::VEC_CLK_SYNTH] = clk_synth_req;
      levels[2*int'(vpiu_pkg::VEC_CLK_SYNTH) +: 2] = clk_synth_lvl;
      pend[vpiu_pkg::VEC_FLASH_ERR] = flash_module_err_req;
      levels[2*int'(vpiu_pkg::VEC_FLASH_ERR) +: 2] = flash_err_lvl;
   end

   // ---------------------------------------------------------------
   // arbitration
   // ---------------------------------------------------------------
   // pure logic: the winner follows the tables within the same cycle
   // ties go to the smaller vector inside the tree
   logic found;
   logic [4:0] win_vec;
   logic [1:0] win_lvl;

   vpiu_arbiter #(
      .N(vpiu_pkg::NUM_VEC)
   ) u_arb (
      .pend(pend),
      .levels(levels),
      .found(found),
      .win_vec(win_vec),
      .win_lvl(win_lvl)
   );

   // ---------------------------------------------------------------
   // registered grant
   // ---------------------------------------------------------------
   vpiu_pkg::vpiu_grant_t grant_r, grant_nxt;

   always_comb begin
      // vector and level stay visible while masked, so the core sees what waits
      grant_nxt.valid = found && (win_lvl >= core_mask_level);
      grant_nxt.vector = win_vec;
      grant_nxt.level = win_lvl;
      // the sum wraps at the top of program space
      grant_nxt.fetch_addr = 21'(vector_table_base + vec_offset(win_vec));
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         grant_r <= '0;
      end else begin
         grant_r <= grant_nxt;
      end
   end

   assign grant = grant_r;

   // ---------------------------------------------------------------
   // boot location
   // ---------------------------------------------------------------
   // the reset cause is sampled every cycle; the core reads it once reset ends
   logic [20:0] boot_r;
   logic [20:0] boot_nxt;

   always_comb begin
      boot_nxt = watchdog_reset ? vpiu_pkg::BOOT_WATCHDOG_ADDR : vpiu_pkg::BOOT_RESET_ADDR;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         boot_r <= vpiu_pkg::BOOT_RESET_ADDR;
      end else begin
         boot_r <= boot_nxt;
      end
   end

   assign boot_addr = boot_r;
endmodule // vpiu_top

// *** sim/tb.sv ***
// testbench for the vectored priority interrupt unit
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [20:0] BASE = 21'h1F_FFF0;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] exc = 4'h0;
   logic [4:0] dbg = 5'h00;
   logic [2:0] swi = 3'h0;
   logic [4:0] per = 5'h00;
   logic [9:0] dbg_lvl = 10'h000;
   logic [9:0] per_lvl = 10'h000;
   logic [1:0] mask_set = 2'h0;
   logic wd = 1'b0;
   logic [20:0] base = BASE;
   // expected vector and level of each source bit, in {per, dbg, exc} order
   logic [4:0] vmap [14] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A, 5'h0B,
      5'h11, 5'h12, 5'h14, 5'h15, 5'h16};
   logic [1:0] lmap [14] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
      2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
   logic [1:0] mask;
   vpiu_pkg::vpiu_grant_t grant;
   logic [20:0] boot_addr;
   int err_total = 0;
   int checks_done = 0;
   always #10 clock = ~clock;
   vpiu_top vpiu_top_inst (.clock(clock), .reset_n(reset_n), .exc_illegal(exc[0]),
      .exc_swi3(exc[1]), .exc_stack_ovf(exc[2]), .exc_misalign(exc[3]), .debug_unit_req(dbg),
      .swi2_req(swi[2]), .swi1_req(swi[1]), .swi0_req(swi[0]), .external_request_a(per[0]),
      .external_request_b(per[1]), .low_voltage_req(per[2]), .clk_synth_req(per[3]),
      .flash_module_err_req(per[4]), .debug_unit_level(dbg_lvl), .periph_level(per_lvl),
      .vector_table_base(base), .core_mask_level(mask), .watchdog_reset(wd),
      .grant(grant), .boot_addr(boot_addr));
   vpiu_core_model vpiu_core_model_inst (.clock(clock), .reset_n(reset_n),
      .mask_set(mask_set), .core_mask_level(mask));
   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task step(); @(posedge clock); #2; endtask
   task chk(string n, logic [28:0] e, logic [28:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   function automatic logic [28:0] gr(logic v, logic [4:0] n, logic [1:0] l);
      return {v, n, l, base + 21'({n, 1'b0})};
   endfunction
   task t_core();
      exc = 4'h3; dbg = 5'h01; dbg_lvl = 10'h3FF;
      step(); chk("illegal", gr(1'b1, 5'h02, 2'h3), grant);
      exc = 4'h2;
      step(); chk("swi3", gr(1'b1, 5'h03, 2'h3), grant);
      exc = 4'h0;
      step(); chk("step", gr(1'b1, 5'h06, 2'h3), grant);
      dbg = 5'h00;
   endtask
   task t_levels();
      dbg = 5'h04; dbg_lvl = 10'h020; per = 5'h01; per_lvl = 10'h002;
      step(); chk("tie", gr(1'b1, 5'h09, 2'h2), grant);
      dbg = 5'h00; per = 5'h11; per_lvl = 10'h300;
      step(); chk("clamp", gr(1'b1, 5'h16, 2'h2), grant);
      per = 5'h00; dbg = 5'h01; dbg_lvl = 10'h000; swi = 3'h1;
      step(); chk("floor", gr(1'b1, 5'h06, 2'h1), grant);
      dbg = 5'h00;
   endtask
   task t_swi();
      for (int i = 0; i < 3; i++) begin
         swi = 3'h7 >> i;
         step(); chk("soft", gr(1'b1, 5'h0E + 5'(i), 2'(2 - i)), grant);
      end
   endtask
   task t_mask();
      mask_set = 2'h3; swi = 3'h4;
      step(); step(); chk("masked", gr(1'b0, 5'h0E, 2'h2), grant);
      mask_set = 2'h2;
      step(); step(); chk("equal", gr(1'b1, 5'h0E, 2'h2), grant);
      mask_set = 2'h0; swi = 3'h0;
   endtask
   task t_boot();
      wd = 1'b1;
      step(); chk("dog", {8'h00, 21'h04_0002}, {8'h00, boot_addr});
      wd = 1'b0;
      step(); chk("cold", {8'h00, 21'h04_0000}, {8'h00, boot_addr});
   endtask
   task t_map();
      dbg_lvl = 10'h000; per_lvl = 10'h3FF;
      for (int i = 0; i < 14; i++) begin
         {per, dbg, exc} = 14'h0001 << i;
         step(); chk("map", gr(1'b1, vmap[i], lmap[i]), grant);
      end
      {per, dbg, exc} = 14'h0000;
   endtask
   task t_base();
      base = 21'h04_0000; exc = 4'h0; swi = 3'h0;
      step(); chk("overlay", gr(1'b0, 5'h00, 2'h0), grant);
      exc = 4'h8;
      step(); chk("relocated", {1'b1, 5'h05, 2'h3, 21'h04_000A}, grant);
      exc = 4'h0; base = BASE;
   endtask
   task close_out();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clock);
      #2 chk("reset grant", 29'h0000_0000, grant);
      chk("reset boot", {8'h00, 21'h04_0000}, {8'h00, boot_addr});
      reset_n = 1'b1;
      t_map(); t_core(); t_levels(); t_swi(); t_mask(); t_base(); t_boot();
      close_out();
   end
   initial begin
      #20000;
      err_total++;
      close_out();
   end
endmodule // tb

// *** sim/vpiu_asserts.sv ***
// checker for the interrupt unit outputs, bound to the top module
module vpiu_chk (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic exc_illegal,
   input wire logic exc_swi3,
   input wire logic [20:0] vector_table_base,
   input wire logic [1:0] core_mask_level,
   input wire logic watchdog_reset,
   input wire vpiu_pkg::vpiu_grant_t grant,
   input wire logic [20:0] boot_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   chk_illegal_wins: assert property (exc_illegal |=> grant.valid && grant.vector == 5'h02)
      else $error("illegal instruction not granted");
   chk_swi3_wins: assert property (exc_swi3 && !exc_illegal |=> grant.vector == 5'h03)
      else $error("soft interrupt 3 lost");
   chk_core_level: assert property (grant.valid && grant.vector <= 5'h05 |-> grant.level == 2'h3)
      else $error("core exception level wrong");
   chk_fetch_sum: assert property (grant.valid |->
      grant.fetch_addr == $past(vector_table_base) + 21'({grant.vector, 1'b0}))
      else $error("fetch address wrong");
   chk_mask_gate: assert property (grant.valid |-> grant.level >= $past(core_mask_level))
      else $error("grant below mask");
   chk_entry_free: assert property (grant.valid |-> grant.vector >= 5'h02)
      else $error("reset overlay granted");
   chk_boot_dog: assert property (watchdog_reset |=> boot_addr == 21'h04_0002)
      else $error("watchdog boot address wrong");
   chk_boot_cold: assert property (!watchdog_reset |=> boot_addr == 21'h04_0000)
      else $error("reset boot address wrong");
   cover property (grant.valid && grant.level == 2'h3);
   cover property (!grant.valid && grant.level < core_mask_level);
   cover property (watchdog_reset ##1 !watchdog_reset);
endmodule // vpiu_chk
bind vpiu_top vpiu_chk vpiu_chk_inst (.clock, .reset_n, .exc_illegal, .exc_swi3,
   .vector_table_base, .core_mask_level, .watchdog_reset, .grant, .boot_addr);

// *** sim/vpiu_core_model.sv ***
// core model: holds its interrupt mask, loaded on a clock edge, cleared at once by reset
module vpiu_core_model (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [1:0] mask_set,
   output logic [1:0] core_mask_level
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) core_mask_level <= 2'h0;
      else core_mask_level <= mask_set;
   end
endmodule // vpiu_core_model
